// *** inc/map_decode_pkg.sv ***
// Purpose: Shared constants for the resource map decoder
// Assumes: APB byte address is four times the register index
// Notes:   Extras and emulate-bit reset values are per mode class; the others are fixed
package map_decode_pkg;
  // Register indices on the APB
  localparam logic [7:0] MODE_CTRL_IDX  = 8'h0b;
  localparam logic [7:0] REG_POS_IDX    = 8'h11;
  localparam logic [7:0] RAM_POS_IDX    = 8'h10;
  localparam logic [7:0] EE_POS_IDX     = 8'h12;
  localparam logic [7:0] MAP_EXTRAS_IDX = 8'h13;
  // Field positions
  localparam int PORT_E_EMULATE_BIT = 0;
  localparam int MAP_STOP_WAIT_BIT  = 0;
  localparam int EE_READ_EN_BIT     = 0;
  localparam int FLASH_EN_BIT       = 0;
  localparam int FLASH_UPPER_BIT    = 1;
  localparam int NARROW_FOLLOW_BIT  = 6;
  // Reset values
  localparam logic [7:0] REG_POS_RST    = 8'h00;
  localparam logic [7:0] RAM_POS_RST    = 8'h08;
  localparam logic [7:0] EE_POS_RST     = 8'h01;
  localparam logic [7:0] EXTRAS_EXP_RST = 8'h0c;
  localparam logic [7:0] EXTRAS_SC_RST  = 8'h0f;
  // Resource geometry
  localparam logic [15:0] EE_LOW_OFS    = 16'h0d00;
  localparam logic [15:0] BDM_ROM_BASE  = 16'hff00;
  localparam logic [8:0]  PORT_E_DATA   = 9'h008;
  localparam logic [8:0]  PORT_E_DIR    = 9'h009;
  // Pin synchroniser settle count after reset release
  localparam logic [1:0]  STRAP_WAIT    = 2'h3;
endpackage : map_decode_pkg

// *** src/resource_map_decoder.sv ***
// Purpose: Address map decoder with relocation and mapping registers
// Assumes: Mode straps are stable around reset release
// Notes:   Decode outputs are registered, one cycle after the request
// Operation
// - Expanded mode with emulate bit moves port E registers outside.
// - Emulate bit: once in normal, ignore first then anytime special.
// - Register block at 0x0000 after reset, any 2K boundary, low 512.
// - Register base bits compare address bits 15 to 11.
// - Position and extras registers write once normal, anytime special.
// - Stop-in-wait bit shuts decode in wait; normal only writable.
// - RAM at 0x0800 after reset, any 2K boundary, low 1K.
// - RAM base bits compare address bits 15 to 11.
// - EEPROM 768 bytes at 0x0d00, base bits give 15 to 12.
// - EEPROM base bits write once normal, anytime special.
// - EEPROM read enable gates only array reads.
// - EEPROM read enable forced 1 single-chip, writable elsewhere.
// - Narrow-follow makes follow region 8-bit in expanded wide only.
// - Follow region sits after register block and moves with it.
// - Follow stretch adds 0..3 stretches in expanded modes.
// - External stretch adds 0..3, resets to 11, expanded only.
// - Upper-half bit picks flash half; ignored when flash disabled.
// - Flash bits reset 0 expanded, 1 single-chip; enable 0 unmaps.
// - RAM, registers, EEPROM, debug ROM win over flash.
// - Strobe, A0 and read/write encode access size and alignment.
// - Only RAM gives strobe and A0 both high, swapped halves.
// - Mapping write changes decode from the following cycle.
// - Priority debug ROM, registers, RAM, EEPROM, flash, external.
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module resource_map_decoder
  import map_decode_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mode_special_n_pin,
  input  wire logic        mode_b_pin,
  input  wire logic        mode_a_pin,
  input  wire logic        cpu_valid,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_write,
  input  wire logic        cpu_wide,
  input  wire logic        debug_rom_active,
  input  wire logic        wait_mode,
  output logic             sel_debug_rom,
  output logic             sel_registers,
  output logic             sel_ram,
  output logic             sel_eeprom,
  output logic             sel_eeprom_ctrl,
  output logic             sel_flash,
  output logic             sel_external,
  output logic             sel_follow,
  output logic             bus_narrow,
  output logic      [1:0]  stretch_count,
  output logic             low_byte_strobe,
  output logic             addr_bit0,
  output logic             read_not_write
);

  // Three-stage synchronisers for the mode straps
  logic [2:0] smodn_s_r, modb_s_r, moda_s_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smodn_s_r <= 3'h0;
      modb_s_r  <= 3'h0;
      moda_s_r  <= 3'h0;
    end else begin
      smodn_s_r <= {smodn_s_r[1:0], mode_special_n_pin};
      modb_s_r  <= {modb_s_r[1:0], mode_b_pin};
      moda_s_r  <= {moda_s_r[1:0], mode_a_pin};
    end
  end

  // Straps caught once, after the synchroniser has filled
  logic [1:0] strap_cnt_r;
  logic       strap_done_r;
  logic       smodn_r, modb_r, moda_r;
  logic       strap_ok;
  assign strap_ok = (smodn_s_r[2] == smodn_s_r[1]) &&
                    (modb_s_r[2] == modb_s_r[1]) &&
                    (moda_s_r[2] == moda_s_r[1]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_r  <= 2'h0;
      strap_done_r <= 1'b0;
      smodn_r      <= 1'b0;
      modb_r       <= 1'b0;
      moda_r       <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_cnt_r != STRAP_WAIT) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end else if (strap_ok) begin
        strap_done_r <= 1'b1;
        smodn_r      <= smodn_s_r[2];
        modb_r       <= modb_s_r[2];
        moda_r       <= moda_s_r[2];
      end
    end
  end

  // Mode classes
  logic special, single_chip, peripheral, expanded, exp_wide;
  assign special     = !smodn_r;
  assign single_chip = !modb_r && !moda_r;
  assign peripheral  = special && modb_r && !moda_r;
  assign expanded    = moda_r;
  assign exp_wide    = modb_r && moda_r;

  // APB decode; bus always ready, unmapped index gives an error
  logic [7:0] idx;
  logic       wr_en, rd_map, hit;
  assign idx   = paddr[9:2];
  assign hit   = (idx == MODE_CTRL_IDX) || (idx == REG_POS_IDX) ||
                 (idx == RAM_POS_IDX) || (idx == EE_POS_IDX) ||
                 (idx == MAP_EXTRAS_IDX);
  assign wr_en = psel && penable && pwrite && hit && strap_done_r;
  assign rd_map = hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Write allowances: normal once, special anytime
  function automatic logic may_write(input logic spc, input logic used);
    may_write = spc || !used;
  endfunction : may_write

  // Mapping registers and their write-once flags
  logic [7:0] reg_pos_r, ram_pos_r, ee_pos_r, extras_r;
  logic       eme_r;
  logic       reg_used_r, ram_used_r, ee_used_r, ext_used_r, eme_used_r;
  logic [7:0] wd;
  assign wd = pwdata[7:0];

  // Register block position and stop-in-wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_pos_r  <= REG_POS_RST;
      reg_used_r <= 1'b0;
    end else if (wr_en && idx == REG_POS_IDX) begin
      reg_used_r <= 1'b1;
      if (may_write(special, reg_used_r))
        reg_pos_r[7:3] <= wd[7:3];
      if (!special)
        reg_pos_r[MAP_STOP_WAIT_BIT] <= wd[MAP_STOP_WAIT_BIT];
    end
  end

  // RAM position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_pos_r  <= RAM_POS_RST;
      ram_used_r <= 1'b0;
    end else if (wr_en && idx == RAM_POS_IDX) begin
      ram_used_r <= 1'b1;
      if (may_write(special, ram_used_r))
        ram_pos_r[7:3] <= wd[7:3];
    end
  end

  // EEPROM position and read enable; enable pinned high in single-chip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_pos_r  <= EE_POS_RST;
      ee_used_r <= 1'b0;
    end else if (wr_en && idx == EE_POS_IDX) begin
      ee_used_r <= 1'b1;
      if (may_write(special, ee_used_r))
        ee_pos_r[7:4] <= wd[7:4];
      if (!single_chip)
        ee_pos_r[EE_READ_EN_BIT] <= wd[EE_READ_EN_BIT];
    end
  end

  // Extras: mode-dependent defaults loaded when straps are caught
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extras_r   <= EXTRAS_EXP_RST;
      ext_used_r <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_cnt_r == STRAP_WAIT && strap_ok)
        extras_r <= (!modb_s_r[2] && !moda_s_r[2]) ?
                    EXTRAS_SC_RST : EXTRAS_EXP_RST;
    end else if (wr_en && idx == MAP_EXTRAS_IDX) begin
      ext_used_r <= 1'b1;
      if (may_write(special, ext_used_r))
        extras_r <= {1'b0, wd[6:0]};
    end
  end

  // Port E emulate: special mode swallows the first write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eme_r      <= 1'b0;
      eme_used_r <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_cnt_r == STRAP_WAIT && strap_ok)
        eme_r <= !smodn_s_r[2];
    end else if (wr_en && idx == MODE_CTRL_IDX) begin
      eme_used_r <= 1'b1;
      if (special ? eme_used_r : !eme_used_r)
        eme_r <= wd[PORT_E_EMULATE_BIT];
    end
  end

  // Read mux; status shows the caught mode straps
  logic [7:0] rd_byte;
  logic       ee_on;
  assign ee_on = single_chip || ee_pos_r[EE_READ_EN_BIT];
  always_comb begin
    rd_byte = 8'h00;
    if (rd_map) begin
      unique case (idx)
        MODE_CTRL_IDX: rd_byte = {smodn_r, modb_r, moda_r, 4'h0, eme_r};
        REG_POS_IDX:   rd_byte = {reg_pos_r[7:3], 2'h0, reg_pos_r[0]};
        RAM_POS_IDX:   rd_byte = {ram_pos_r[7:3], 3'h0};
        EE_POS_IDX:    rd_byte = {ee_pos_r[7:4], 3'h0, ee_on};
        default:       rd_byte = extras_r;
      endcase
    end
  end

  // Read data held in a flip-flop, updated during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= {24'h0, rd_byte};
  end

  // Address region hits from the stored bases
  logic        hit_dbg, hit_reg, hit_ram, hit_ee, hit_fl, hit_fol;
  logic        port_e_out, flash_on, flash_hi, ee_any;
  logic [15:0] a;
  assign a        = cpu_addr;
  assign flash_on = extras_r[FLASH_EN_BIT];
  assign flash_hi = extras_r[FLASH_UPPER_BIT];
  assign hit_dbg  = debug_rom_active && (a >= BDM_ROM_BASE);
  // Register block: low 512 bytes of a 2K block
  assign hit_reg  = (a[15:11] == reg_pos_r[7:3]) && (a[10:9] == 2'h0);
  // Follow region: next 512 bytes of the same block
  assign hit_fol  = (a[15:11] == reg_pos_r[7:3]) && (a[10:9] == 2'h1);
  assign hit_ram  = (a[15:11] == ram_pos_r[7:3]) && !a[10];
  assign ee_any   = (a[15:12] == ee_pos_r[7:4]) &&
                    ({4'h0, a[11:0]} >= EE_LOW_OFS);
  // Read enable gates only array reads; writes still reach it
  assign hit_ee   = ee_any && (cpu_write || ee_on);
  assign hit_fl   = flash_on && (a[15] == flash_hi);
  // Port E registers go external in expanded mode with emulate set
  assign port_e_out = expanded && eme_r &&
                      (a[8:0] == PORT_E_DATA || a[8:0] == PORT_E_DIR);

  // Priority decode of one access
  logic dec_dbg, dec_reg, dec_ram, dec_ee, dec_fl, dec_ext, dec_fol;
  always_comb begin
    dec_dbg = 1'b0;
    dec_reg = 1'b0;
    dec_ram = 1'b0;
    dec_ee  = 1'b0;
    dec_fl  = 1'b0;
    dec_ext = 1'b0;
    dec_fol = 1'b0;
    if (hit_dbg)
      dec_dbg = 1'b1;
    else if (hit_reg && !port_e_out)
      dec_reg = 1'b1;
    else if (hit_ram && !hit_reg)
      dec_ram = 1'b1;
    else if (hit_ee && !hit_reg)
      dec_ee = 1'b1;
    else if (hit_fl && !hit_reg)
      dec_fl = 1'b1;
    else if (expanded) begin
      dec_ext = 1'b1;
      dec_fol = hit_fol;
    end
  end

  // Bus width and stretch, meaningful in expanded modes only
  logic       narrow_nxt;
  logic [1:0] stretch_nxt;
  always_comb begin
    narrow_nxt  = 1'b0;
    stretch_nxt = 2'h0;
    if (expanded && dec_ext) begin
      narrow_nxt = !exp_wide ||
                   (dec_fol && extras_r[NARROW_FOLLOW_BIT]);
      stretch_nxt = dec_fol ? extras_r[5:4]
                            : extras_r[3:2];
    end
  end

  // Size encoding; only RAM may take a misaligned wide access
  logic strobe_nxt;
  always_comb begin
    if (!cpu_wide)
      strobe_nxt = !a[0];
    else if (a[0] && dec_ram)
      strobe_nxt = 1'b1;
    else
      strobe_nxt = 1'b0;
  end

  // Registered decode; wait shutdown blanks it. New bases act next cycle.
  logic active;
  assign active = cpu_valid && strap_done_r && !peripheral &&
                  !(wait_mode && reg_pos_r[MAP_STOP_WAIT_BIT]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_debug_rom   <= 1'b0;
      sel_registers   <= 1'b0;
      sel_ram         <= 1'b0;
      sel_eeprom      <= 1'b0;
      sel_eeprom_ctrl <= 1'b0;
      sel_flash       <= 1'b0;
      sel_external    <= 1'b0;
      sel_follow      <= 1'b0;
    end else begin
      sel_debug_rom   <= active && dec_dbg;
      sel_registers   <= active && dec_reg;
      sel_ram         <= active && dec_ram;
      sel_eeprom      <= active && dec_ee;
      sel_eeprom_ctrl <= active && ee_any && !ee_on;
      sel_flash       <= active && dec_fl;
      sel_external    <= active && dec_ext;
      sel_follow      <= active && dec_fol;
    end
  end

  // Access type pins, registered with the selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_narrow      <= 1'b0;
      stretch_count   <= 2'h0;
      low_byte_strobe <= 1'b0;
      addr_bit0       <= 1'b0;
      read_not_write  <= 1'b1;
    end else if (active) begin
      bus_narrow      <= narrow_nxt;
      stretch_count   <= stretch_nxt;
      low_byte_strobe <= strobe_nxt;
      addr_bit0       <= a[0];
      read_not_write  <= !cpu_write;
    end else begin
      bus_narrow      <= 1'b0;
      stretch_count   <= 2'h0;
      low_byte_strobe <= 1'b0;
      addr_bit0       <= 1'b0;
      read_not_write  <= 1'b1;
    end
  end

endmodule : resource_map_decoder

// *** verif/map_decode_sva.sv ***
// Purpose: Port assertions for the resource map decoder
// Assumes: Bound into the decoder by the bench top
// Notes:   Selects and type pins lag the request by one edge
`timescale 1ns/100ps
module map_decode_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        cpu_valid,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_write,
  input wire logic        cpu_wide,
  input wire logic        debug_rom_active,
  input wire logic        sel_debug_rom,
  input wire logic        sel_registers,
  input wire logic        sel_ram,
  input wire logic        sel_eeprom,
  input wire logic        sel_eeprom_ctrl,
  input wire logic        sel_flash,
  input wire logic        sel_external,
  input wire logic        low_byte_strobe,
  input wire logic        addr_bit0,
  input wire logic        read_not_write
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Type checks only on cycles that really selected something
  wire logic [6:0] sv = {sel_debug_rom, sel_registers, sel_ram, sel_eeprom,
                         sel_eeprom_ctrl, sel_flash, sel_external};
  idle_quiet_a: assert property (
    !cpu_valid |=> !(|sv)) else $error("select without a request");
  // The control-range flag may ride along with the select that wins
  one_select_a: assert property (
    $onehot0({sel_debug_rom, sel_registers, sel_ram, sel_eeprom,
              sel_flash, sel_external}))
    else $error("more than one resource selected");
  ee_ctrl_excl_a: assert property (
    sel_eeprom_ctrl |-> !sel_eeprom) else $error("array read while off");
  swap_ram_only_a: assert property (
    low_byte_strobe && addr_bit0 |-> sel_ram) else $error("swap off RAM");
  ram_swap_a: assert property (
    cpu_valid && cpu_wide && cpu_addr[0] ##1 sel_ram
      |-> low_byte_strobe && addr_bit0) else $error("RAM odd word");
  addr_low_a: assert property (
    cpu_valid ##1 |sv |-> addr_bit0 == $past(cpu_addr[0]))
    else $error("address bit 0 wrong");
  dir_pin_a: assert property (
    cpu_valid ##1 |sv |-> read_not_write == !$past(cpu_write))
    else $error("direction pin wrong");
  byte_strobe_a: assert property (
    cpu_valid && !cpu_wide ##1 |sv |-> low_byte_strobe != addr_bit0)
    else $error("byte access strobe wrong");
  even_word_a: assert property (
    cpu_valid && cpu_wide && !cpu_addr[0] ##1 |sv
      |-> !low_byte_strobe && !addr_bit0) else $error("even word wrong");
  debug_first_a: assert property (
    cpu_valid && debug_rom_active && (&cpu_addr[15:8]) ##1 |sv
      |-> sel_debug_rom) else $error("debug ROM lost priority");
endmodule : map_decode_sva

// *** verif/ext_mem_model.sv ***
// Purpose: External memory seen across the expansion bus
// Assumes: One select cycle per external request
// Notes:   Tallies bus time; stretches lengthen each access
`timescale 1ns/100ps
module ext_mem_model (
  input  wire logic       pclk,
  input  wire logic       sel_external,
  input  wire logic [1:0] stretch_count,
  output int              ext_hits
);
  // Each access costs one E cycle plus its stretches
  initial ext_hits = 0;
  always @(posedge pclk) begin
    if (sel_external) begin
      ext_hits <= ext_hits + 1 + int'(stretch_count);
    end
  end
endmodule : ext_mem_model

// *** verif/resource_map_decoder_tb.sv ***
// Purpose: Self-checking bench for the resource map decoder
// Assumes: Normal expanded wide straps, then special single-chip after reset
// Notes:   Drivers queue expectations; monitors pop and compare
`timescale 1ns/100ps
module resource_map_decoder_tb;
  import map_decode_pkg::*;
  typedef struct {logic [32:0] v; logic [32:0] m;} exp_t;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, req_d = 1'h0;
  logic [9:0]  paddr  = 10'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic mode_special_n_pin = 1'h1, mode_b_pin = 1'h1, mode_a_pin = 1'h1;
  logic cpu_valid = 1'h0, cpu_write = 1'h0, cpu_wide = 1'h0;
  logic [15:0] cpu_addr = 16'h0;
  logic debug_rom_active = 1'h0, wait_mode = 1'h0;
  logic sel_debug_rom, sel_registers, sel_ram, sel_eeprom, sel_eeprom_ctrl;
  logic sel_flash, sel_external, sel_follow, bus_narrow;
  logic low_byte_strobe, addr_bit0, read_not_write;
  logic [1:0]  stretch_count;
  exp_t        rdq[$], decq[$];
  int          err_total = 0, compares = 0, ext_exp = 0, ext_hits;
  wire logic [13:0] dec_out = {sel_debug_rom, sel_registers, sel_ram,
    sel_eeprom, sel_eeprom_ctrl, sel_flash, sel_external, sel_follow,
    bus_narrow, stretch_count, low_byte_strobe, addr_bit0, read_not_write};

  resource_map_decoder u_dut (.*);
  ext_mem_model u_ext (.pclk(pclk), .sel_external(sel_external),
                       .stretch_count(stretch_count), .ext_hits(ext_hits));

  // 50 MHz bus clock
  always #10 pclk = ~pclk;

  task automatic check(string what, logic [32:0] seen, exp_t e);
    compares++;
    if ((seen & e.m) !== e.v) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", what, e.v, seen & e.m);
    end
  endtask : check

  task automatic finish_test();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // One APB transfer; held until pready is seen high
  task automatic apb(logic wr, logic [7:0] idx, logic [7:0] d, exp_t e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    if (!wr) rdq.push_back(e);
    @(posedge pclk);
    penable <= 1'h1;
    // Only the watchdog ends a wait that never sees pready
    do @(posedge pclk); while (!pready);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rd(logic [7:0] idx, logic [7:0] v);
    apb(1'h0, idx, 8'h0, '{{25'h0, v}, {33{1'h1}}});
  endtask : rd

  task automatic wr(logic [7:0] idx, logic [7:0] d);
    apb(1'h1, idx, d, '{33'h0, 33'h0});
  endtask : wr

  // k = {wide, write}; xs = {narrow, stretch}; s lists the selects
  task automatic dec(logic [15:0] a, logic [1:0] k, logic [7:0] s,
                     logic [2:0] xs);
    exp_t e;
    @(posedge pclk);
    cpu_valid <= 1'h1;
    cpu_addr <= a;
    cpu_wide <= k[1];
    cpu_write <= k[0];
    e.v = {19'h0, s, xs, (k[1] ? a[0] & s[5] : !a[0]), a[0], !k[0]};
    e.m = {19'h0, 8'hff, {3{s[1]}}, 3'h7};
    if (s == 8'h0) e.m[2:0] = 3'h0;  // Type pins open when shut down
    e.v &= e.m;
    if (s[1]) ext_exp += 1 + int'(xs[1:0]);
    decq.push_back(e);
  endtask : dec

  // Drop the request so APB traffic is not decoded meanwhile
  task automatic idle();
    @(posedge pclk);
    cpu_valid <= 1'h0;
  endtask : idle

  // Monitors: read data at the access edge, decode one edge on
  always @(posedge pclk) begin
    req_d <= cpu_valid & presetn;
    if (psel && penable && pready && !pwrite)
      check("apb_read", {pslverr, prdata}, rdq.pop_front());
  end
  always @(negedge pclk) begin
    if (req_d) check("decode", {19'h0, dec_out}, decq.pop_front());
  end

  // Hang guard, far beyond the fewer than 200 cycles needed
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    finish_test();
  end

  initial begin
    logic [31:0] r;
    void'($urandom(68));
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (6) @(posedge pclk);
    rd(MODE_CTRL_IDX, 8'he0);
    rd(REG_POS_IDX, REG_POS_RST);
    rd(RAM_POS_IDX, RAM_POS_RST);
    rd(EE_POS_IDX, EE_POS_RST);
    rd(MAP_EXTRAS_IDX, EXTRAS_EXP_RST);
    apb(1'h0, 8'h0, 8'h0, '{33'h100000000, 33'h100000000});
    dec(16'h0000, 2'h0, 8'h40, 3'h0);
    dec(16'h0201, 2'h1, 8'h03, 3'h0);
    dec(16'h0d00, 2'h2, 8'h10, 3'h0);
    dec(16'h8001, 2'h2, 8'h02, 3'h3);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      dec(16'h0800 + {7'h0, r[8:0]}, r[10:9], 8'h20, 3'h0);
    end
    idle();
    wr(MAP_EXTRAS_IDX, 8'h67);
    dec(16'h8000, 2'h2, 8'h04, 3'h0);
    dec(16'h0300, 2'h2, 8'h03, 3'h6);
    dec(16'h4000, 2'h0, 8'h02, 3'h1);
    idle();
    debug_rom_active <= 1'h1;
    dec(16'hff10, 2'h0, 8'h80, 3'h0);
    idle();
    debug_rom_active <= 1'h0;
    wr(MAP_EXTRAS_IDX, 8'h00);
    rd(MAP_EXTRAS_IDX, 8'h67);
    wr(REG_POS_IDX, 8'h11);
    rd(REG_POS_IDX, 8'h11);
    dec(16'h1000, 2'h0, 8'h40, 3'h0);
    dec(16'h1200, 2'h0, 8'h03, 3'h6);
    dec(16'h0000, 2'h0, 8'h02, 3'h1);
    idle();
    wait_mode <= 1'h1;
    dec(16'h1000, 2'h0, 8'h00, 3'h0);
    idle();
    wr(REG_POS_IDX, 8'h20);
    rd(REG_POS_IDX, 8'h10);
    dec(16'h1000, 2'h0, 8'h40, 3'h0);
    idle();
    wait_mode <= 1'h0;
    wr(EE_POS_IDX, 8'h20);
    dec(16'h2d00, 2'h0, 8'h0a, 3'h1);
    idle();
    wr(EE_POS_IDX, 8'h31);
    rd(EE_POS_IDX, 8'h21);
    dec(16'h2eff, 2'h0, 8'h10, 3'h0);
    idle();
    wr(MODE_CTRL_IDX, 8'h01);
    dec(16'h1008, 2'h0, 8'h02, 3'h1);
    dec(16'h1009, 2'h1, 8'h02, 3'h1);
    dec(16'h100a, 2'h0, 8'h40, 3'h0);
    idle();
    repeat (3) @(posedge pclk);
    check("ext_hits", 33'(ext_hits), '{33'(ext_exp), {33{1'h1}}});
    // Mid-run reset into special single-chip straps
    presetn <= 1'h0;
    mode_special_n_pin <= 1'h0;
    mode_b_pin <= 1'h0;
    mode_a_pin <= 1'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (6) @(posedge pclk);
    rd(MODE_CTRL_IDX, 8'h01);
    rd(MAP_EXTRAS_IDX, EXTRAS_SC_RST);
    wr(MODE_CTRL_IDX, 8'h00);
    rd(MODE_CTRL_IDX, 8'h01);
    wr(MODE_CTRL_IDX, 8'h00);
    rd(MODE_CTRL_IDX, 8'h00);
    wr(EE_POS_IDX, 8'h40);
    wr(EE_POS_IDX, 8'h50);
    rd(EE_POS_IDX, 8'h51);
    wr(MAP_EXTRAS_IDX, 8'h03);
    wr(MAP_EXTRAS_IDX, 8'h01);
    rd(MAP_EXTRAS_IDX, 8'h01);
    wr(REG_POS_IDX, 8'h01);
    rd(REG_POS_IDX, 8'h00);
    wait_mode <= 1'h1;
    dec(16'h0000, 2'h0, 8'h40, 3'h0);
    dec(16'h4000, 2'h2, 8'h04, 3'h0);
    dec(16'h8000, 2'h2, 8'h00, 3'h0);
    dec(16'h0801, 2'h2, 8'h20, 3'h0);
    idle();
    wait_mode <= 1'h0;
    repeat (3) @(posedge pclk);
    finish_test();
  end
endmodule : resource_map_decoder_tb

bind resource_map_decoder map_decode_sva u_sva (.*);
